// File: design/dpwd_defs.svh
// Offsets, field positions, reset values and timing counts for the block
`ifndef DPWD_DEFS_SVH
`define DPWD_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DPWD_OFF_CTRL      12'h000
`define DPWD_OFF_STATIC    12'h004
`define DPWD_OFF_DYN       12'h008
`define DPWD_OFF_TRIM      12'h00C
`define DPWD_OFF_STATUS    12'h010
`define DPWD_OFF_SELECTED  12'h014

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define DPWD_CTRL_STATIC_BIT   0
`define DPWD_CTRL_BOTTOM_BIT   1
`define DPWD_CODE_INV_BIT      7
`define DPWD_TAP_W             7
`define DPWD_CODE_W            8
`define DPWD_TRIM_W            4
`define DPWD_RST_CODE          8'h00
`define DPWD_RST_CTRL          2'h0
`define DPWD_RESP_OKAY         2'h0
`define DPWD_RESP_SLVERR       2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define DPWD_STEP_PS           25
`define DPWD_STEPS             128

`endif

// File: design/dpwd_pkg.sv
// Types shared by the write delay control block
package dpwd_pkg;

  typedef struct packed {
    logic       invert;
    logic [6:0] tap;
  } dpwd_delay_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] resp;
    logic [31:0] data;
  } dpwd_rd_s;

  typedef enum logic [1:0] {
    DPWD_WR_IDLE,
    DPWD_WR_RESP
  } dpwd_wr_e;

endpackage

// File: design/dpwd_top.sv
// Write delay control, gearing clocks and strobe status for one DDR group
`timescale 1ns/100ps
`default_nettype none
`include "dpwd_defs.svh"

module dpwd_top
  import dpwd_pkg::*;
(
  // System clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Link clock from the strobe side
  input  wire logic        link_clk,
  // AXI4-Lite write channels
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Delay line and DLL
  input  wire logic [6:0]  dll_delay_code,
  output var  logic [6:0]  delay_tap,
  output var  logic        delay_invert,
  output var  logic [6:0]  input_base_delay,
  output var  logic [3:0]  input_delay_trim,
  // Strobe pad side, link clock domain
  input  wire logic        raw_strobe_in,
  input  wire logic        strobe_pad_oe_n,
  input  wire logic        strobe_write_control,
  input  wire logic        core_strobe_out,
  input  wire logic        pin_data_in,
  output var  logic        gearing_clock_phase_a,
  output var  logic        gearing_clock_phase_b,
  output var  logic        strobe_pad_out,
  output var  logic        strobe_pad_tri_n,
  // Core side
  output var  logic        preamble_detect,
  output var  logic        capture_valid_flag,
  output var  logic        captured_data
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [1:0]  ctrl;
  logic [7:0]  static_code, group_write_delay;
  logic [3:0]  trim;
  logic [31:0] awaddr_q, wdata_q, wd;
  logic        aw_held, w_held, cap_valid_sys, pre_sys, wr_fire;
  dpwd_wr_e    wr_state;
  logic [11:0] wa;
  assign wa      = aw_held ? awaddr_q[11:0] : s_axi_awaddr;
  assign wd      = w_held ? wdata_q : s_axi_wdata;
  assign wr_fire = (aw_held | (s_axi_awvalid & s_axi_awready))
                   & (w_held | (s_axi_wvalid & s_axi_wready))
                   & (wr_state == DPWD_WR_IDLE);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q  <= 32'h0000_0000;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held  <= 1'b1;
        awaddr_q <= {20'h0_0000, s_axi_awaddr};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
    end
  end

  // Each ready while its own address or data is not parked and no write response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready)
                       && (wr_state == DPWD_WR_IDLE) && !wr_fire;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready)
                       && (wr_state == DPWD_WR_IDLE) && !wr_fire;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl              <= `DPWD_RST_CTRL;
      static_code       <= `DPWD_RST_CODE;
      group_write_delay <= `DPWD_RST_CODE;
      trim              <= 4'h0;
    end else if (wr_fire && (w_held || s_axi_wstrb[0])) begin
      case (wa)
        `DPWD_OFF_CTRL:   ctrl              <= wd[1:0];
        `DPWD_OFF_STATIC: static_code       <= wd[7:0];
        `DPWD_OFF_DYN:    group_write_delay <= wd[7:0];
        `DPWD_OFF_TRIM:   trim              <= wd[3:0];
        default:          ctrl              <= ctrl;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state     <= DPWD_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DPWD_RESP_OKAY;
    end else begin
      case (wr_state)
        DPWD_WR_IDLE: begin
          if (wr_fire) begin
            wr_state     <= DPWD_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wa <= `DPWD_OFF_TRIM && wa[1:0] == 2'b00) ?
                            `DPWD_RESP_OKAY : `DPWD_RESP_SLVERR;
          end
        end
        DPWD_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state     <= DPWD_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wr_state <= DPWD_WR_IDLE;
      endcase
    end
  end

  // Read channel, one access at a time
  dpwd_rd_s rd_next;
  always_comb begin
    rd_next.valid = 1'b1;
    rd_next.resp  = `DPWD_RESP_OKAY;
    case (s_axi_araddr)
      `DPWD_OFF_CTRL:     rd_next.data = {30'h0000_0000, ctrl};
      `DPWD_OFF_STATIC:   rd_next.data = {24'h00_0000, static_code};
      `DPWD_OFF_DYN:      rd_next.data = {24'h00_0000, group_write_delay};
      `DPWD_OFF_TRIM:     rd_next.data = {28'h000_0000, trim};
      `DPWD_OFF_STATUS:   rd_next.data = {30'h0000_0000, pre_sys,
                                          cap_valid_sys};
      `DPWD_OFF_SELECTED: rd_next.data = {24'h00_0000, delay_invert,
                                          delay_tap};
      default: begin
        rd_next.data = 32'h0000_0000;
        rd_next.resp = `DPWD_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DPWD_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= rd_next.valid;
      s_axi_rdata   <= rd_next.data;
      s_axi_rresp   <= rd_next.resp;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // Delay selection
  // ****************************************************************
  dpwd_delay_s sel;
  assign sel = ctrl[`DPWD_CTRL_STATIC_BIT] ? static_code : group_write_delay;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_tap        <= 7'h00;
      delay_invert     <= 1'b0;
      input_base_delay <= 7'h00;
      input_delay_trim <= 4'h0;
    end else begin
      delay_tap        <= sel.tap;
      delay_invert     <= sel.invert;
      input_base_delay <= dll_delay_code;
      // input trim, none on bottom edge
      input_delay_trim <= ctrl[`DPWD_CTRL_BOTTOM_BIT] ? 4'h0 : trim;
    end
  end

  // ****************************************************************
  // Link clock domain
  // ****************************************************************
  logic [1:0] inv_sync, bot_sync, rst_sync, swc_sync, core_sync, phase_cnt;
  logic       link_rst_n, cap_q, cap_valid_link, pre_link;
  always_ff @(posedge link_clk) begin
    inv_sync  <= {inv_sync[0], delay_invert};
    bot_sync  <= {bot_sync[0], ctrl[`DPWD_CTRL_BOTTOM_BIT]};
    rst_sync  <= {rst_sync[0], aresetn};
    swc_sync  <= {swc_sync[0], strobe_write_control};
    core_sync <= {core_sync[0], core_strobe_out};
  end
  assign link_rst_n = rst_sync[1];

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      phase_cnt             <= 2'h0;
      gearing_clock_phase_a <= 1'b0;
      gearing_clock_phase_b <= 1'b0;
    end else begin
      phase_cnt             <= phase_cnt + 2'h1;
      gearing_clock_phase_a <= phase_cnt[1] ^ inv_sync[1];
      gearing_clock_phase_b <= (phase_cnt[1] ^ phase_cnt[0]) ^ inv_sync[1];
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      strobe_pad_out   <= 1'b0;
      strobe_pad_tri_n <= 1'b1;
    end else begin
      strobe_pad_out   <= swc_sync[1] ? core_sync[1] : strobe_pad_out;
      strobe_pad_tri_n <= swc_sync[1] ? strobe_pad_oe_n : 1'b1;
    end
  end

  // input register part, valid on capture
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      cap_q          <= 1'b0;
      cap_valid_link <= 1'b0;
      pre_link       <= 1'b1;
    end else begin
      cap_q          <= pin_data_in;
      cap_valid_link <= bot_sync[1] | raw_strobe_in;
      pre_link       <= raw_strobe_in | strobe_pad_oe_n;
    end
  end

  // ****************************************************************
  // Core side crossings
  // ****************************************************************
  logic [1:0] val_sync, dat_sync, pre_sync;
  always_ff @(posedge aclk) begin
    val_sync <= {val_sync[0], cap_valid_link};
    dat_sync <= {dat_sync[0], cap_q};
    pre_sync <= {pre_sync[0], pre_link};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_valid_sys      <= 1'b0;
      pre_sys            <= 1'b0;
      capture_valid_flag <= 1'b0;
      preamble_detect    <= 1'b0;
      captured_data      <= 1'b0;
    end else begin
      cap_valid_sys      <= val_sync[1];
      pre_sys            <= pre_sync[1];
      capture_valid_flag <= val_sync[1];
      preamble_detect    <= pre_sync[1];
      captured_data      <= dat_sync[1];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_TAP_FOLLOWS: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 ##1 aresetn |-> delay_tap == $past(sel.tap))
    else $error("Tap does not follow selected code");
  AST_INV_FOLLOWS: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 ##1 aresetn |-> delay_invert == $past(sel.invert))
    else $error("Invert does not follow code bit seven");
  AST_STATIC_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl[0] |=> delay_tap == $past(static_code[6:0]))
    else $error("Static code not applied");
  AST_DYN_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl[0] |=> {delay_invert, delay_tap} == $past(group_write_delay))
    else $error("Group code not applied");
  AST_BOTTOM_TRIM: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl[1] |=> input_delay_trim == 4'h0)
    else $error("Trim active on bottom edge");
  AST_DLL_REF: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 ##1 aresetn |-> input_base_delay == $past(dll_delay_code))
    else $error("DLL code not passed");
  AST_VALID_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    val_sync[1] |=> capture_valid_flag)
    else $error("Valid flag missed");
  AST_PREAMBLE: assert property (@(posedge aclk) disable iff (!aresetn)
    pre_sync[1] |=> preamble_detect)
    else $error("Preamble detect missed");
  AST_TRI_GATED: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    !swc_sync[1] |=> strobe_pad_tri_n)
    else $error("Strobe pad driven without control");

endmodule
`default_nettype wire

// File: sim/dpwd_ddr_group_model.sv
// Behavioural DDR3 data and strobe group on the pad side of the block
`timescale 1ns/100ps
`default_nettype none
module dpwd_ddr_group_model
  import dpwd_pkg::*;
(
  // Link clock
  input  wire logic link_clk,
  // Pad lines toward the block
  output var  logic raw_strobe_in,
  output var  logic strobe_pad_oe_n,
  output var  logic pin_data_in
);
  // ****************************************************************
  // Line behaviour
  // ****************************************************************
  // released strobe line biased high
  initial begin
    raw_strobe_in   = 1'b1;
    strobe_pad_oe_n = 1'b1;
    pin_data_in     = 1'b0;
  end
  // Data line never holds a stale value
  always @(posedge link_clk) begin
    pin_data_in <= ~pin_data_in;
  end
  // one group with its own strobe
  task automatic park_low();
    @(posedge link_clk);
    strobe_pad_oe_n <= 1'b0;
    raw_strobe_in   <= 1'b0;
  endtask
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge link_clk);
      raw_strobe_in <= ~raw_strobe_in;
    end
  endtask
  task automatic release_line();
    @(posedge link_clk);
    strobe_pad_oe_n <= 1'b1;
    raw_strobe_in   <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: sim/dpwd_top_test.sv
// Self-checking bench for the write delay control block
`timescale 1ns/100ps
`default_nettype none
`include "dpwd_defs.svh"
module dpwd_top_test
  import dpwd_pkg::*;
;
  logic        aclk, aresetn, link_clk;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdata_q;
  logic [3:0]  wstrb, trim;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [6:0]  dll_code, tap, base;
  logic        inv, raw, oe_n, swc, core_out, pin_d;
  logic        ph_a, ph_b, pad_out, tri_n, prmb, cvalid, cdata;
  int          mismatches = 0;
  int          tests_run = 0;
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever #32 link_clk = ~link_clk;
  end
  dpwd_top i_dpwd_top (
    .aclk(aclk), .aresetn(aresetn), .link_clk(link_clk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .dll_delay_code(dll_code), .delay_tap(tap),
    .delay_invert(inv), .input_base_delay(base),
    .input_delay_trim(trim), .raw_strobe_in(raw),
    .strobe_pad_oe_n(oe_n), .strobe_write_control(swc),
    .core_strobe_out(core_out), .pin_data_in(pin_d),
    .gearing_clock_phase_a(ph_a), .gearing_clock_phase_b(ph_b),
    .strobe_pad_out(pad_out), .strobe_pad_tri_n(tri_n),
    .preamble_detect(prmb), .capture_valid_flag(cvalid),
    .captured_data(cdata));
  dpwd_ddr_group_model i_dpwd_ddr_group_model (
    .link_clk(link_clk), .raw_strobe_in(raw),
    .strobe_pad_oe_n(oe_n), .pin_data_in(pin_d));
  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [11:0] a);
    bit done = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        r = rresp;
        rdata_q = rdata;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [11:0] offs [5] = '{`DPWD_OFF_CTRL, `DPWD_OFF_STATIC,
      `DPWD_OFF_DYN, `DPWD_OFF_TRIM, `DPWD_OFF_SELECTED};
    check("tap_rst", 32'(tap), 32'h0000_0000);
    foreach (offs[i]) begin
      rd(offs[i]);
      check("reg_rst", rdata_q, 32'h0000_0000);
    end
    rd(12'h020);
    check("unmapped", {rdata_q[29:0], r}, 32'h0000_0002);
    wr(`DPWD_OFF_STATUS, 32'h0000_0001);
    check("ro_write", 32'(r), 32'(`DPWD_RESP_SLVERR));
  endtask
  task automatic t_dynamic();
    logic [7:0] codes [4] = '{8'h7f, 8'h80, 8'h01, 8'hff};
    foreach (codes[i]) begin
      wr(`DPWD_OFF_DYN, 32'(codes[i]));
      settle(0);
      check("tap", 32'(tap), 32'(codes[i][6:0]));
      check("invert", 32'(inv), 32'(codes[i][7]));
      rd(`DPWD_OFF_SELECTED);
      check("selected", rdata_q, 32'(codes[i]));
    end
  endtask
  task automatic t_static();
    wr(`DPWD_OFF_STATIC, 32'h0000_00b5);
    wr(`DPWD_OFF_CTRL, 32'h0000_0001);
    settle(0);
    check("static", 32'({inv, tap}), 32'h0000_00b5);
    wr(`DPWD_OFF_DYN, 32'h0000_0044);
    settle(0);
    check("static_hold", 32'({inv, tap}), 32'h0000_00b5);
    wr(`DPWD_OFF_CTRL, 32'h0000_0000);
    settle(0);
    check("dyn_back", 32'({inv, tap}), 32'h0000_0044);
  endtask
  task automatic t_trim_dll();
    wr(`DPWD_OFF_TRIM, 32'h0000_000a);
    dll_code <= 7'h5a;
    settle(2);
    check("trim", 32'(trim), 32'h0000_000a);
    check("dll_base", 32'(base), 32'h0000_005a);
    i_dpwd_ddr_group_model.park_low();
    settle(30);
    check("valid_parked", 32'(cvalid), 32'h0000_0000);
    wr(`DPWD_OFF_CTRL, 32'h0000_0002);
    settle(60);
    check("bottom_trim", 32'(trim), 32'h0000_0000);
    check("bottom_valid", 32'(cvalid), 32'h0000_0001);
    wr(`DPWD_OFF_CTRL, 32'h0000_0000);
    i_dpwd_ddr_group_model.release_line();
    settle(30);
  endtask
  task automatic t_strobe();
    logic hi, d_hi, d_lo;
    check("prmb_idle", 32'(prmb), 32'h0000_0001);
    i_dpwd_ddr_group_model.park_low();
    settle(30);
    check("prmb_driven", 32'(prmb), 32'h0000_0000);
    hi   = 1'b0;
    d_hi = 1'b0;
    d_lo = 1'b0;
    // Strobe level alternates every link cycle, so look over a window
    fork
      i_dpwd_ddr_group_model.toggle(24);
      repeat (60) begin
        settle(1);
        hi   = hi | cvalid;
        d_hi = d_hi | cdata;
        d_lo = d_lo | !cdata;
      end
    join
    check("cap_valid", 32'(hi), 32'h0000_0001);
    check("cap_data", 32'({d_hi, d_lo}), 32'h0000_0003);
    settle(30);
    check("cap_idle", 32'(cvalid), 32'h0000_0000);
    i_dpwd_ddr_group_model.release_line();
    settle(30);
    check("prmb_release", 32'(prmb), 32'h0000_0001);
    rd(`DPWD_OFF_STATUS);
    check("status_valid", 32'(rdata_q[1:0]), 32'h0000_0003);
  endtask
  task automatic t_pad_gear();
    logic a [8];
    logic b [8];
    check("tri_off", 32'(tri_n), 32'h0000_0001);
    i_dpwd_ddr_group_model.park_low();
    for (int v = 0; v < 2; v++) begin
      @(posedge aclk);
      swc      <= 1'b1;
      core_out <= v[0];
      settle(60);
      check("pad_out", 32'({pad_out, tri_n}), 32'({v[0], 1'b0}));
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge link_clk);
      a[i] = ph_a;
      b[i] = ph_b;
    end
    for (int i = 2; i < 8; i++) begin
      check("gear_lead", 32'(b[i-1]), 32'(a[i]));
      check("gear_div", 32'(a[i]), 32'(!a[i-2]));
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial begin
    aresetn  = 1'b0;
    awaddr   = 12'h000;
    awvalid  = 1'b0;
    wdata    = 32'h0000_0000;
    wstrb    = 4'h0;
    wvalid   = 1'b0;
    bready   = 1'b0;
    araddr   = 12'h000;
    arvalid  = 1'b0;
    rready   = 1'b0;
    dll_code = 7'h00;
    swc      = 1'b0;
    core_out = 1'b0;
    // Long enough for the link side to see reset too
    repeat (40) @(posedge aclk);
    aresetn <= 1'b1;
    settle(2);
    t_reset();
    t_dynamic();
    t_static();
    t_trim_dll();
    t_strobe();
    t_pad_gear();
    wrap_up();
  end
endmodule
`default_nettype wire
